// ==== shared/aisc_pkg.sv ====
// aisc_pkg: register map, field positions, reset values and timing for the input scan control block
package aisc_pkg;
   // register byte offsets on the local register port
   localparam logic [7:0]  OFF_SCAN_SYNC     = 8'h04;
   localparam logic [7:0]  OFF_SAMPLE_PORT   = 8'h08;
   localparam logic [7:0]  OFF_BUF_CTRL      = 8'h0C;
   localparam logic [7:0]  OFF_RATE_A        = 8'h10;
   localparam logic [7:0]  OFF_RATE_B        = 8'h14;
   localparam logic [7:0]  OFF_BOARD_CTRL    = 8'h00;
   // board control register fields
   localparam int          BCR_FUNC_LSB      = 0;
   localparam int          BCR_OFFSET_BIN    = 6;
   localparam int          BCR_INPUT_SYNC    = 12;
   localparam logic [31:0] BCR_RESET         = 32'h0000_0040;
   // scan and sync control fields
   localparam int          SS_SIZE_LSB       = 0;
   localparam int          SS_CLK_LSB        = 2;
   localparam int          SS_XOUT_LSB       = 8;
   localparam int          SS_CASCADE        = 10;
   localparam int          SS_SINGLE         = 11;
   localparam int          SS_CHAN_LSB       = 12;
   localparam int          SS_TWO_CH         = 17;
   localparam logic [31:0] SS_RESET          = 32'h0000_02D2;
   localparam logic [31:0] SS_MASK           = 32'h0003_FFFF;
   // rate generator fields
   localparam int          RATE_DIS          = 16;
   localparam logic [31:0] RATE_A_RESET      = 32'h0001_07D0;
   localparam logic [31:0] RATE_B_RESET      = 32'h0001_0050;
   localparam logic [31:0] RATE_MASK         = 32'h0001_FFFF;
   // input buffer control fields
   localparam int          BC_CLEAR          = 15;
   localparam int          BC_FLAG           = 16;
   localparam logic [14:0] THRESH_RESET      = 15'h7FFE;
   // scan clock sources
   localparam logic [1:0]  SRC_RATE_A        = 2'h0;
   localparam logic [1:0]  SRC_RATE_B        = 2'h1;
   localparam logic [1:0]  SRC_EXT           = 2'h2;
   localparam logic [1:0]  SRC_SOFT          = 2'h3;
   // sizes
   localparam int          BUF_DEPTH         = 32768;
   localparam int          XFER_DEPTH        = 256;
   // conversion timing: one conversion each 80 master clocks at 24 MHz is 300 kHz
   localparam int          MASTER_HZ         = 24000000;
   localparam int          CONV_HZ           = 300000;
   localparam int          CONV_CYCLES       = MASTER_HZ / CONV_HZ;
endpackage

// ==== logic/aisc_sample_ram.sv ====
// aisc_sample_ram: single-port-write, registered-read sample memory
`timescale 1ns/100ps
`default_nettype none
module aisc_sample_ram #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 32768,
   parameter int AW    = $clog2(DEPTH)
) (
   // clock
   input  wire logic             sys_clk_in,
   // write side
   input  wire logic             wr_en_in,
   input  wire logic [AW-1:0]    wr_addr_in,
   input  wire logic [WIDTH-1:0] wr_data_in,
   // read side
   input  wire logic [AW-1:0]    rd_addr_in,
   output logic      [WIDTH-1:0] rd_data_out
);
   logic [WIDTH-1:0] mem_r [DEPTH];

   // no reset: memory content is don't-care until written
   always_ff @(posedge sys_clk_in) begin
      if (wr_en_in) begin
         mem_r[wr_addr_in] <= wr_data_in;
      end
      rd_data_out <= mem_r[rd_addr_in];
   end
endmodule
`default_nettype wire

// ==== logic/aisc_top.sv ====
// aisc_top: analog input scan control with rate generators, sample buffer and control registers
`timescale 1ns/100ps
`default_nettype none
module aisc_top #(
   parameter int DEPTH      = aisc_pkg::BUF_DEPTH,
   parameter int XFER_DEPTH = aisc_pkg::XFER_DEPTH,
   parameter int CONV_CYC   = aisc_pkg::CONV_CYCLES
) (
   // clock and reset
   input  wire logic        sys_clk_in,
   input  wire logic        rst_n_in,
   // register port
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   input  wire logic [31:0] reg_wdata_in,
   output logic      [31:0] reg_rdata_out,
   output logic             reg_rvalid_out,
   // converter
   output logic             conv_start_out,
   output logic      [4:0]  conv_chan_out,
   output logic      [2:0]  input_function_select_out,
   input  wire logic        conv_done_in,
   input  wire logic [15:0] conv_data_in,
   // sync and monitors
   input  wire logic        ext_sync_in,
   output logic             ext_sync_out,
   output logic             rate_a_tick_out,
   output logic             rate_b_tick_out,
   output logic             two_compl_out,
   output logic             thresh_rise_out,
   output logic             thresh_fall_out
);
   localparam int AW = $clog2(DEPTH);
   localparam int XW = $clog2(XFER_DEPTH);

   //------------------------------------------------------------
   // registers
   //------------------------------------------------------------
   logic [31:0] bcr_r;
   logic [31:0] ss_r;
   logic [16:0] rate_a_r;
   logic [16:0] rate_b_r;
   logic [14:0] thresh_r;
   logic        clear_r;
   logic        flag_r;

   wire wr_bcr  = reg_wr_in && (reg_addr_in == aisc_pkg::OFF_BOARD_CTRL);
   wire wr_ss   = reg_wr_in && (reg_addr_in == aisc_pkg::OFF_SCAN_SYNC);
   wire wr_bc   = reg_wr_in && (reg_addr_in == aisc_pkg::OFF_BUF_CTRL);
   wire wr_ra   = reg_wr_in && (reg_addr_in == aisc_pkg::OFF_RATE_A);
   wire wr_rb   = reg_wr_in && (reg_addr_in == aisc_pkg::OFF_RATE_B);
   wire rd_port = reg_rd_in && (reg_addr_in == aisc_pkg::OFF_SAMPLE_PORT);

   //------------------------------------------------------------
   // rate generators
   //------------------------------------------------------------
   logic [15:0] cnt_a_r;
   logic [15:0] cnt_b_r;
   logic        tick_a_r;
   logic        tick_b_r;

   wire        dis_a    = rate_a_r[aisc_pkg::RATE_DIS];
   wire        dis_b    = rate_b_r[aisc_pkg::RATE_DIS];
   wire        cascade  = ss_r[aisc_pkg::SS_CASCADE];
   wire        step_b   = cascade ? tick_a_r : 1'b1;
   wire [15:0] div_a    = rate_a_r[15:0];
   wire [15:0] div_b    = rate_b_r[15:0];
   wire        tc_a     = (cnt_a_r <= 16'h0001);
   wire        tc_b     = (cnt_b_r <= 16'h0001);

   // divisor N ticks each N steps, zero as one; a stopped counter rests at zero so the new divisor applies at once
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_a_r  <= 16'h0000;
         tick_a_r <= 1'b0;
      end else if (dis_a) begin
         cnt_a_r  <= 16'h0000;
         tick_a_r <= 1'b0;
      end else begin
         tick_a_r <= tc_a;
         cnt_a_r  <= tc_a ? div_a : cnt_a_r - 16'h0001;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_b_r  <= 16'h0000;
         tick_b_r <= 1'b0;
      end else if (dis_b) begin
         cnt_b_r  <= 16'h0000;
         tick_b_r <= 1'b0;
      end else begin
         tick_b_r <= step_b && tc_b;
         if (step_b) begin
            cnt_b_r <= tc_b ? div_b : cnt_b_r - 16'h0001;
         end
      end
   end

   //------------------------------------------------------------
   // scan trigger selection
   //------------------------------------------------------------
   logic ext_d_r;
   logic soft_seen_r;

   wire [1:0] clk_src   = ss_r[aisc_pkg::SS_CLK_LSB +: 2];
   wire       ext_fall  = ext_d_r && !ext_sync_in;
   wire       soft_bit  = bcr_r[aisc_pkg::BCR_INPUT_SYNC];
   wire       trig      = (clk_src == aisc_pkg::SRC_RATE_A) ? tick_a_r :
                          (clk_src == aisc_pkg::SRC_RATE_B) ? tick_b_r :
                          (clk_src == aisc_pkg::SRC_EXT)    ? ext_fall :
                          (soft_bit && !soft_seen_r);

   //------------------------------------------------------------
   // scan sequencer
   //------------------------------------------------------------
   typedef enum {AISC_IDLE, AISC_CONV, AISC_WAIT} aisc_state_t;
   aisc_state_t state_r;
   logic [4:0]  chan_r;
   logic [5:0]  left_r;
   logic [$clog2(CONV_CYC+1)-1:0] pace_r;

   wire [1:0] scan_size = ss_r[aisc_pkg::SS_SIZE_LSB +: 2];
   wire       two_ch    = ss_r[aisc_pkg::SS_TWO_CH];
   wire       single    = ss_r[aisc_pkg::SS_SINGLE] && !two_ch;
   wire [5:0] nchan     = two_ch ? 6'h02 : single ? 6'h01 : (6'h04 << scan_size);
   wire [4:0] first_ch  = single ? ss_r[aisc_pkg::SS_CHAN_LSB +: 5] : 5'h00;
   wire       pace_done = (pace_r == '0);
   wire       scan_busy = (state_r != AISC_IDLE);

   // triggers arriving during a busy scan are missed, as for an over-fast scan clock
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_r <= AISC_IDLE;
         chan_r  <= 5'h00;
         left_r  <= 6'h00;
         pace_r  <= '0;
      end else if (clear_r) begin
         state_r <= AISC_IDLE;
         pace_r  <= '0;
      end else begin
         if (!pace_done) begin
            pace_r <= pace_r - 1'b1;
         end
         case (state_r)
            AISC_IDLE: begin
               if (trig) begin
                  chan_r  <= first_ch;
                  left_r  <= nchan;
                  state_r <= AISC_CONV;
               end
            end
            AISC_CONV: begin
               if (pace_done) begin
                  pace_r  <= CONV_CYC[$bits(pace_r)-1:0] - 1'b1;
                  state_r <= AISC_WAIT;
               end
            end
            AISC_WAIT: begin
               if (conv_done_in) begin
                  chan_r  <= chan_r + 5'h01;
                  left_r  <= left_r - 6'h01;
                  state_r <= (left_r == 6'h01) ? AISC_IDLE : AISC_CONV;
               end
            end
            default: state_r <= AISC_IDLE;
         endcase
      end
   end

   //------------------------------------------------------------
   // transfer FIFO and sample buffer share one memory ring
   //------------------------------------------------------------
   // buffered samples occupy [rd, mid); transfer FIFO occupies [mid, wr)
   logic [AW:0]   wr_ptr_r;
   logic [AW:0]   mid_ptr_r;
   logic [AW:0]   rd_ptr_r;
   logic [16:0]   rdata_r;
   logic          rd_pend_r;
   logic [16:0]   ram_q;

   wire [AW:0] total    = wr_ptr_r - rd_ptr_r;
   wire [AW:0] in_xfer  = wr_ptr_r - mid_ptr_r;
   wire [AW:0] in_buf   = mid_ptr_r - rd_ptr_r;
   wire        full     = (total == DEPTH[AW:0]);
   wire        xfer_mv  = (in_xfer != '0);
   wire        buf_nemp = (in_buf != '0);
   wire        store    = conv_done_in && (state_r == AISC_WAIT) && !full && !clear_r;
   wire        pop      = rd_port && buf_nemp;
   wire        two_c    = !bcr_r[aisc_pkg::BCR_OFFSET_BIN];
   wire [15:0] coded    = {conv_data_in[15] ^ two_c, conv_data_in[14:0]};
   wire [16:0] wr_word  = {(chan_r == 5'h00), coded};
   wire        bc_clear = wr_bc && reg_wdata_in[aisc_pkg::BC_CLEAR];

   aisc_sample_ram #(
      .WIDTH (17),
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_ram (
      .sys_clk_in  (sys_clk_in),
      .wr_en_in    (store),
      .wr_addr_in  (wr_ptr_r[AW-1:0]),
      .wr_data_in  (wr_word),
      .rd_addr_in  (rd_ptr_r[AW-1:0]),
      .rd_data_out (ram_q)
   );

   // transfer FIFO moves one word per cycle; only the shared DEPTH bounds it, XFER_DEPTH is not used
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_ptr_r  <= '0;
         mid_ptr_r <= '0;
         rd_ptr_r  <= '0;
      end else if (clear_r) begin
         wr_ptr_r  <= '0;
         mid_ptr_r <= '0;
         rd_ptr_r  <= '0;
      end else begin
         if (store) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (xfer_mv) begin
            mid_ptr_r <= mid_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
      end
   end

   // read data: memory answers one cycle after the address
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_pend_r <= 1'b0;
      end else begin
         rd_pend_r <= reg_rd_in;
      end
   end

   //------------------------------------------------------------
   // threshold flag
   //------------------------------------------------------------
   wire flag_nxt = ({{(16-AW){1'b0}}, in_buf} > {2'b00, thresh_r});

   //------------------------------------------------------------
   // register writes and self-clearing bits
   //------------------------------------------------------------
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bcr_r       <= aisc_pkg::BCR_RESET;
         ss_r        <= aisc_pkg::SS_RESET;
         rate_a_r    <= aisc_pkg::RATE_A_RESET[16:0];
         rate_b_r    <= aisc_pkg::RATE_B_RESET[16:0];
         thresh_r    <= aisc_pkg::THRESH_RESET;
         clear_r     <= 1'b0;
         flag_r      <= 1'b0;
         ext_d_r     <= 1'b0;
         soft_seen_r <= 1'b0;
      end else begin
         ext_d_r <= ext_sync_in;
         flag_r  <= flag_nxt;
         // clearing takes one cycle, then the bit drops by itself
         clear_r <= bc_clear;
         if (wr_bc) begin
            thresh_r <= reg_wdata_in[14:0];
         end
         if (wr_ss) begin
            ss_r <= reg_wdata_in & aisc_pkg::SS_MASK;
         end
         if (wr_ra) begin
            rate_a_r <= reg_wdata_in[16:0];
         end
         if (wr_rb) begin
            rate_b_r <= reg_wdata_in[16:0];
         end
         // software sync bit stays high until its scan completes
         if (wr_bcr) begin
            bcr_r <= reg_wdata_in;
         end else if (soft_seen_r && !scan_busy && !trig) begin
            bcr_r[aisc_pkg::BCR_INPUT_SYNC] <= 1'b0;
         end
         soft_seen_r <= (clk_src == aisc_pkg::SRC_SOFT) && soft_bit && !(soft_seen_r && !scan_busy);
      end
   end

   //------------------------------------------------------------
   // read mux: sample port reads are registered through the memory
   //------------------------------------------------------------
   logic        port_pend_r;
   logic        port_ok_r;
   logic [31:0] reg_q_r;

   wire [31:0] bc_word = {15'h0000, flag_r, clear_r, thresh_r};
   wire [31:0] rd_mux  = (reg_addr_in == aisc_pkg::OFF_BOARD_CTRL) ? bcr_r :
                         (reg_addr_in == aisc_pkg::OFF_SCAN_SYNC)  ? ss_r :
                         (reg_addr_in == aisc_pkg::OFF_BUF_CTRL)   ? bc_word :
                         (reg_addr_in == aisc_pkg::OFF_RATE_A)     ? {15'h0000, rate_a_r} :
                         (reg_addr_in == aisc_pkg::OFF_RATE_B)     ? {15'h0000, rate_b_r} :
                         32'h0000_0000;

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         port_pend_r <= 1'b0;
         port_ok_r   <= 1'b0;
         reg_q_r     <= 32'h0000_0000;
      end else begin
         port_pend_r <= rd_port;
         port_ok_r   <= pop;
         reg_q_r     <= rd_mux;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_r <= 17'h00000;
      end else if (port_pend_r) begin
         rdata_r <= port_ok_r ? ram_q : 17'h00000;
      end
   end

   // sample port answers one cycle after the others, so rvalid comes a cycle later
   logic rvalid_r;
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= port_pend_r;
      end
   end

   assign reg_rdata_out  = rvalid_r ? {15'h0000, rdata_r} : reg_q_r;
   assign reg_rvalid_out = rvalid_r || (rd_pend_r && !port_pend_r);

   //------------------------------------------------------------
   // outputs
   //------------------------------------------------------------
   logic flag_d_r;
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         flag_d_r <= 1'b0;
      end else begin
         flag_d_r <= flag_r;
      end
   end

   wire [1:0] xout_sel = ss_r[aisc_pkg::SS_XOUT_LSB +: 2];
   assign ext_sync_out = (xout_sel == 2'h2) ? ext_sync_in :
                         (xout_sel == 2'h0) ? !trig : 1'b1;
   assign conv_start_out            = (state_r == AISC_CONV) && pace_done;
   assign conv_chan_out             = chan_r;
   assign input_function_select_out = bcr_r[aisc_pkg::BCR_FUNC_LSB +: 3];
   assign rate_a_tick_out           = tick_a_r;
   assign rate_b_tick_out           = tick_b_r;
   assign two_compl_out             = two_c;
   assign thresh_rise_out           = flag_r && !flag_d_r;
   assign thresh_fall_out           = !flag_r && flag_d_r;
endmodule
`default_nettype wire

// ==== tb/aisc_asserts.sv ====
// checker: port-level assertions for the input scan control block
`timescale 1ns/100ps
`default_nettype none
module aisc_asserts (
   // clock and reset
   input wire logic        sys_clk_in,
   input wire logic        rst_n_in,
   // register port
   input wire logic [7:0]  reg_addr_in,
   input wire logic        reg_wr_in,
   input wire logic        reg_rd_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic [31:0] reg_rdata_out,
   input wire logic        reg_rvalid_out,
   // monitors
   input wire logic [2:0]  input_function_select_out,
   input wire logic        ext_sync_in,
   input wire logic        ext_sync_out,
   input wire logic        rate_a_tick_out,
   input wire logic        rate_b_tick_out,
   input wire logic        two_compl_out
);
   // ----------------------------------------
   // shadow of the written control fields
   // ----------------------------------------
   logic [15:0] div_a_r;
   logic        dis_a_r;
   logic        casc_r;
   logic [1:0]  xout_r;
   wire         wr_a    = reg_wr_in && reg_addr_in == aisc_pkg::OFF_RATE_A;
   wire         wr_ss   = reg_wr_in && reg_addr_in == aisc_pkg::OFF_SCAN_SYNC;
   wire         wr_bc   = reg_wr_in && reg_addr_in == aisc_pkg::OFF_BOARD_CTRL;
   wire         rd_port = reg_rd_in && reg_addr_in == aisc_pkg::OFF_SAMPLE_PORT;
   wire [2:0]   w_func  = reg_wdata_in[2:0];
   wire         w_ob    = reg_wdata_in[6];
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         div_a_r <= 16'h07D0;
         dis_a_r <= 1'b1;
         casc_r  <= 1'b0;
         xout_r  <= 2'h2;
      end else begin
         if (wr_a) begin
            div_a_r <= reg_wdata_in[15:0];
            dis_a_r <= reg_wdata_in[16];
         end
         if (wr_ss) begin
            casc_r <= reg_wdata_in[10];
            xout_r <= reg_wdata_in[9:8];
         end
      end
   end
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!rst_n_in);
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   sequence s_a_gap5;
      rate_a_tick_out && div_a_r == 16'd5 && !dis_a_r && !wr_a ##1 (!wr_a)[*4];
   endsequence
   a_sync_pass: assert property (xout_r == 2'h2 |-> ext_sync_out == ext_sync_in)
      else $error("sync output does not follow sync input");
   a_tick_single: assert property (rate_a_tick_out && div_a_r > 16'd1 |=> !rate_a_tick_out)
      else $error("generator tick longer than one cycle");
   a_tick_period: assert property (s_a_gap5 |=> rate_a_tick_out && !$past(rate_a_tick_out)
      && !$past(rate_a_tick_out, 2) && !$past(rate_a_tick_out, 3) && !$past(rate_a_tick_out, 4))
      else $error("generator period differs from divisor");
   a_tick_gate: assert property (dis_a_r && $past(dis_a_r) |-> !rate_a_tick_out)
      else $error("disabled generator ticked");
   a_casc_source: assert property (casc_r && $past(casc_r) && rate_b_tick_out
      |-> rate_a_tick_out || $past(rate_a_tick_out))
      else $error("cascaded generator ticked without a first generator tick");
   a_func_follow: assert property (wr_bc ##1 (!wr_bc)[*2]
      |-> input_function_select_out == $past(w_func, 2))
      else $error("function select does not follow board control");
   a_coding_level: assert property (wr_bc ##1 (!wr_bc)[*2] |-> two_compl_out == !$past(w_ob, 2))
      else $error("coding select does not follow board control");
   a_reg_answer: assert property (reg_rd_in && !rd_port |=> reg_rvalid_out)
      else $error("register read not answered after one cycle");
   a_port_answer: assert property (rd_port |-> ##2 reg_rvalid_out)
      else $error("sample port read not answered after two cycles");
   a_port_upper: assert property (rd_port ##2 reg_rvalid_out |-> reg_rdata_out[31:17] == 15'h0)
      else $error("sample upper bits not zero");
endmodule
bind aisc_top aisc_asserts u_aisc_asserts (
   .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
   .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
   .reg_rvalid_out(reg_rvalid_out), .input_function_select_out(input_function_select_out),
   .ext_sync_in(ext_sync_in), .ext_sync_out(ext_sync_out), .rate_a_tick_out(rate_a_tick_out),
   .rate_b_tick_out(rate_b_tick_out), .two_compl_out(two_compl_out));
`default_nettype wire

// ==== tb/aisc_conv_model.sv ====
// converter model: answers each conversion start with a fixed code per channel
`timescale 1ns/100ps
`default_nettype none
module aisc_conv_model #(
   parameter int LAT = 2
) (
   // clock and reset
   input  wire logic        sys_clk_in,
   input  wire logic        rst_n_in,
   // request
   input  wire logic        conv_start_in,
   input  wire logic [4:0]  conv_chan_in,
   // result
   output logic             conv_done_out,
   output logic      [15:0] conv_data_out
);
   logic [4:0] chan_r;
   int         wait_r;
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         chan_r <= 5'h0;
         wait_r <= 0;
         conv_done_out <= 1'b0;
         conv_data_out <= 16'h5A5A;
      end else begin
         conv_done_out <= 1'b0;
         // outside a result the data lines never keep the last code
         conv_data_out <= ~conv_data_out;
         if (conv_start_in) begin
            chan_r <= conv_chan_in;
            wait_r <= LAT;
         end else if (wait_r == 1) begin
            conv_done_out <= 1'b1;
            case (chan_r[1:0])
               2'h0: conv_data_out <= 16'h8000;
               2'h1: conv_data_out <= 16'hFFFF;
               2'h2: conv_data_out <= 16'h0000;
               default: conv_data_out <= 16'h7FFF;
            endcase
            wait_r <= 0;
         end else if (wait_r > 1) begin
            wait_r <= wait_r - 1;
         end
      end
   end
endmodule
`default_nettype wire

// ==== tb/test_aisc_top.sv ====
// testbench for the input scan control block
`timescale 1ns/100ps
`default_nettype none
module test_aisc_top;
   logic sys_clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, xs_in = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, na, nb;
   logic rvalid, cstart, cdone, xs_out, ta, tb, twos, trise, tfall;
   logic [4:0] cchan;
   logic [2:0] fsel;
   logic [15:0] cdata;
   logic [15:0] codes [4] = '{16'h8000, 16'hFFFF, 16'h0000, 16'h7FFF};
   int mismatches = 0, checks_done = 0, rises = 0, falls = 0;
   always #5 sys_clk = ~sys_clk;
   always @(negedge sys_clk) begin
      rises = rises + int'(trise);
      falls = falls + int'(tfall);
   end
   aisc_top #(.DEPTH(64), .XFER_DEPTH(16), .CONV_CYC(4)) u_aisc_top (
      .sys_clk_in(sys_clk), .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .conv_start_out(cstart),
      .conv_chan_out(cchan), .input_function_select_out(fsel), .conv_done_in(cdone), .conv_data_in(cdata),
      .ext_sync_in(xs_in), .ext_sync_out(xs_out), .rate_a_tick_out(ta), .rate_b_tick_out(tb),
      .two_compl_out(twos), .thresh_rise_out(trise), .thresh_fall_out(tfall));
   aisc_conv_model u_aisc_conv_model (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .conv_start_in(cstart),
      .conv_chan_in(cchan), .conv_done_out(cdone), .conv_data_out(cdata));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(negedge sys_clk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge sys_clk);
      wr = 1'b0;
      @(negedge sys_clk);
   endtask
   task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      int n;
      @(negedge sys_clk);
      addr = a;
      rd = 1'b1;
      @(negedge sys_clk);
      rd = 1'b0;
      n = 0;
      while (rvalid !== 1'b1 && n < 6) begin
         @(negedge sys_clk);
         n++;
      end
      chk(what, exp, (rvalid === 1'b1) ? rdata : ~exp);
      @(negedge sys_clk);
   endtask
   task automatic count(input int cyc);
      na = 32'h0;
      nb = 32'h0;
      repeat (cyc) begin
         @(negedge sys_clk);
         na = na + {31'h0, ta};
         nb = nb + {31'h0, tb};
      end
   endtask
   task automatic scan();
      @(negedge sys_clk);
      xs_in = 1'b0;
      repeat (3) @(negedge sys_clk);
      xs_in = 1'b1;
      repeat (100) @(negedge sys_clk);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge sys_clk);
      mismatches++;
      $display("BAD watchdog expected done seen hang");
      print_verdict();
   end
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      rst_n = 1'b1;
      rchk("thresh_reset", 8'h0C, 32'h0000_7FFE);
      rchk("rate_a_reset", 8'h10, 32'h0001_07D0);
      rchk("rate_b_reset", 8'h14, 32'h0001_0050);
      rchk("unmapped", 8'h40, 32'h0);
      $display("test resets done");
      wreg(8'h10, 32'h5);
      count(100);
      chk("ticks_a", 32'd20, na);
      wreg(8'h04, 32'h0000_06D2);
      wreg(8'h14, 32'h10);
      repeat (20) @(negedge sys_clk);
      count(160);
      chk("casc_a", 32'd32, na);
      chk("casc_b", 32'd2, nb);
      repeat (1500) @(negedge sys_clk);
      wreg(8'h10, 32'h0001_0005);
      wreg(8'h14, 32'h0001_0003);
      repeat (300) @(negedge sys_clk);
      count(50);
      chk("stopped", 32'h0, na | nb);
      // generator scans of sixteen channels overfilled the shrunken buffer
      for (int i = 0; i < 64; i++) rchk("full", 8'h08, {15'h0, i % 16 == 0, codes[i % 4]});
      rchk("drained", 8'h08, 32'h0);
      $display("test generators done");
      for (int f = 0; f < 8; f++) begin
         wreg(8'h00, 32'h40 | f);
         chk("function", f, {29'h0, fsel});
      end
      chk("offset_bin", 32'h0, {31'h0, twos});
      wreg(8'h0C, 32'h2);
      wreg(8'h04, 32'h0000_0208);
      scan();
      rchk("flag_high", 8'h0C, 32'h0001_0002);
      for (int i = 0; i < 4; i++) rchk("sample", 8'h08, {15'h0, i == 0, codes[i]});
      rchk("flag_low", 8'h0C, 32'h2);
      chk("flag_edges", 32'h0001_0001, {rises[15:0], falls[15:0]});
      $display("test offset binary done");
      wreg(8'h00, 32'h0);
      chk("twos", 32'h1, {31'h0, twos});
      wreg(8'h08, 32'h1234);
      scan();
      for (int i = 0; i < 4; i++) rchk("twos_sample", 8'h08, {15'h0, i == 0, codes[i] ^ 16'h8000});
      rchk("no_write", 8'h08, 32'h0);
      $display("test twos done");
      @(negedge sys_clk);
      xs_in = 1'b0;
      repeat (10) @(negedge sys_clk);
      xs_in = 1'b1;
      wreg(8'h0C, 32'h8002);
      rchk("clear_drop", 8'h0C, 32'h2);
      repeat (80) @(negedge sys_clk);
      rchk("aborted", 8'h08, 32'h0);
      $display("test clear done");
      print_verdict();
   end
endmodule
`default_nettype wire
